// ---- src/fai_pkg.sv ----
// Package: constants and types for the flash identification readout host
// Overview of operation
// - Host may enter mode by holding high voltage on address pin nine.
// - Protection query puts group address on high bits; bit zero means protected.
// - Host may enter mode by command sequence without high voltage.
// - Bank address on top three bits during third write confines identification.
package fai_pkg;
  // ********************************
  // Address layout
  // ********************************
  localparam int ADDR_W       = 22;
  localparam int DATA_W       = 16;
  localparam int HV_BIT       = 9;
  localparam int BANK_LSB     = 19;
  localparam int GROUP_LSB    = 12;
  localparam int LOW_W        = 4;
  localparam logic [3:0] LOC_MAKER = 4'h0;
  localparam logic [3:0] LOC_DEV1  = 4'h1;
  localparam logic [3:0] LOC_PROT  = 4'h2;
  localparam logic [3:0] LOC_LOCK  = 4'h3;
  localparam logic [3:0] LOC_DEV2  = 4'hE;
  localparam logic [3:0] LOC_DEV3  = 4'hF;
  localparam int PROT_BIT     = 0;
  localparam int FACT_LOCK_BIT = 7;
  localparam int CUST_LOCK_BIT = 6;
  // ********************************
  // Command cycles (encodings left open)
  // ********************************
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  ID_CMD_DATA  = 8'h90;
  localparam logic [7:0]  RESET_DATA   = 8'hF0;
  // ********************************
  // Bus timing
  // ********************************
  localparam int CLK_NS       = 100;
  localparam int ACCESS_NS    = 300;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;
  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {FAI_OP_HV, FAI_OP_ENTER, FAI_OP_READ, FAI_OP_EXIT} fai_op_t;
  typedef struct packed {
    fai_op_t             op;
    logic                die_two;
    logic [2:0]          bank;
    logic [ADDR_W-1:0]   addr;
  } fai_req_t;
  typedef struct packed {
    logic                protected_grp;
    logic                fact_locked;
    logic                cust_locked;
    logic [DATA_W-1:0]   word;
  } fai_rsp_t;
  typedef struct packed {
    logic                die_one_select_n;
    logic                die_two_select_n;
    logic                oe_n;
    logic                we_n;
    logic                identification_high_voltage;
    logic [ADDR_W-1:0]   addr;
  } fai_pins_t;
endpackage

// ---- src/fai_host.sv ----
// Host controller that reads identification codes from the dual-die flash
`timescale 1ns/100ps
`default_nettype none
module fai_host #(
  parameter int ACC_CYC = fai_pkg::ACCESS_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        req_valid,
  input  wire fai_pkg::fai_req_t           req,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output fai_pkg::fai_rsp_t                rsp,
  output fai_pkg::fai_pins_t               pins,
  output logic [fai_pkg::DATA_W-1:0]       dq_out,
  output logic                             dq_oe_n,
  input  wire logic [fai_pkg::DATA_W-1:0]  dq_in
);
  // Counter width bounds the access time that can be served
  if (ACC_CYC < 1 || ACC_CYC >= (1 << fai_pkg::CNT_W)) begin : g_acc_chk
    $error("ACC_CYC out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_WR_SET, ST_WR_PULSE, ST_WR_HOLD, ST_RD, ST_DONE} fai_state_t;

  // ********************************
  // Sequencer state
  // ********************************
  fai_state_t                  st_r, st_nxt;
  logic [fai_pkg::CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [1:0]                  wr_idx_r, wr_idx_nxt;
  logic [1:0]                  wr_last_r, wr_last_nxt;
  fai_pkg::fai_req_t           req_r, req_nxt;
  fai_pkg::fai_pins_t          pins_r, pins_nxt;
  logic [fai_pkg::DATA_W-1:0]  dq_r, dq_nxt;
  logic                        oe_r, oe_nxt;
  fai_pkg::fai_rsp_t           rsp_r, rsp_nxt;
  logic                        rv_r, rv_nxt;
  logic                        rdy_r, rdy_nxt;

  function automatic fai_pkg::fai_pins_t idle_pins();
    fai_pkg::fai_pins_t p;
    p = '0;
    p.die_one_select_n = 1'b1;
    p.die_two_select_n = 1'b1;
    p.oe_n = 1'b1;
    p.we_n = 1'b1;
    return p;
  endfunction

  // Address for write cycle k of a command
  function automatic logic [fai_pkg::ADDR_W-1:0] cmd_addr(input fai_pkg::fai_req_t r, input logic [1:0] k);
    logic [fai_pkg::ADDR_W-1:0] a;
    a = '0;
    if (r.op == fai_pkg::FAI_OP_EXIT) begin
      a = '0;
    end else if (k == 2'h0) begin
      a[11:0] = fai_pkg::UNLOCK1_ADDR;
    end else if (k == 2'h1) begin
      a[11:0] = fai_pkg::UNLOCK2_ADDR;
    end else begin
      a[11:0] = fai_pkg::UNLOCK1_ADDR;
      a[fai_pkg::BANK_LSB +: 3] = r.bank;
    end
    return a;
  endfunction

  function automatic logic [fai_pkg::DATA_W-1:0] cmd_data(input fai_pkg::fai_req_t r, input logic [1:0] k);
    logic [fai_pkg::DATA_W-1:0] d;
    d = '0;
    if (r.op == fai_pkg::FAI_OP_EXIT) begin
      d[7:0] = fai_pkg::RESET_DATA;
    end else if (k == 2'h0) begin
      d[7:0] = fai_pkg::UNLOCK1_DATA;
    end else if (k == 2'h1) begin
      d[7:0] = fai_pkg::UNLOCK2_DATA;
    end else begin
      d[7:0] = fai_pkg::ID_CMD_DATA;
    end
    return d;
  endfunction

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_idx_nxt = wr_idx_r;
    wr_last_nxt = wr_last_r;
    req_nxt = req_r;
    pins_nxt = pins_r;
    dq_nxt = dq_r;
    oe_nxt = oe_r;
    rsp_nxt = rsp_r;
    rv_nxt = 1'b0;
    rdy_nxt = rdy_r;
    case (st_r)
      ST_IDLE: begin
        if (req_valid && rdy_r) begin
          req_nxt = req;
          rdy_nxt = 1'b0;
          cnt_nxt = fai_pkg::CNT_W'(ACC_CYC);
          pins_nxt = idle_pins();
          // Keep the high voltage level between reads of an HV session
          pins_nxt.identification_high_voltage = (req.op == fai_pkg::FAI_OP_HV);
          case (req.op)
            fai_pkg::FAI_OP_ENTER, fai_pkg::FAI_OP_EXIT: begin
              wr_idx_nxt = 2'h0;
              wr_last_nxt = (req.op == fai_pkg::FAI_OP_EXIT) ? 2'h0 : 2'h2;
              pins_nxt.addr = cmd_addr(req, 2'h0);
              pins_nxt.die_one_select_n = req.die_two;
              pins_nxt.die_two_select_n = ~req.die_two;
              dq_nxt = cmd_data(req, 2'h0);
              oe_nxt = 1'b0;
              st_nxt = ST_WR_SET;
            end
            default: begin
              // The whole request address is driven with address bit nine forced low; the unused select stays high
              pins_nxt.addr = req.addr;
              pins_nxt.addr[fai_pkg::HV_BIT] = 1'b0;
              pins_nxt.die_one_select_n = req.die_two;
              pins_nxt.die_two_select_n = ~req.die_two;
              pins_nxt.oe_n = 1'b0;
              oe_nxt = 1'b1;
              st_nxt = ST_RD;
            end
          endcase
        end
      end
      ST_WR_SET: begin
        pins_nxt.we_n = 1'b0;
        st_nxt = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (cnt_r > fai_pkg::CNT_W'(1)) begin
          cnt_nxt = cnt_r - fai_pkg::CNT_W'(1);
        end else begin
          pins_nxt.we_n = 1'b1;
          cnt_nxt = fai_pkg::CNT_W'(ACC_CYC);
          st_nxt = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // Flash takes data at the rising strobe, so address and data wait a cycle
        if (wr_idx_r == wr_last_r) begin
          st_nxt = ST_DONE;
        end else begin
          wr_idx_nxt = wr_idx_r + 2'h1;
          pins_nxt.addr = cmd_addr(req_r, wr_idx_r + 2'h1);
          dq_nxt = cmd_data(req_r, wr_idx_r + 2'h1);
          st_nxt = ST_WR_SET;
        end
      end
      ST_RD: begin
        if (cnt_r > fai_pkg::CNT_W'(1)) begin
          cnt_nxt = cnt_r - fai_pkg::CNT_W'(1);
        end else begin
          // Sample the whole data word and status bits after the access time
          rsp_nxt.word = dq_in;
          rsp_nxt.protected_grp = dq_in[fai_pkg::PROT_BIT];
          rsp_nxt.fact_locked = dq_in[fai_pkg::FACT_LOCK_BIT];
          rsp_nxt.cust_locked = dq_in[fai_pkg::CUST_LOCK_BIT];
          pins_nxt.oe_n = 1'b1;
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        pins_nxt.die_one_select_n = 1'b1;
        pins_nxt.die_two_select_n = 1'b1;
        oe_nxt = 1'b1;
        rv_nxt = 1'b1;
        rdy_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      wr_idx_r <= '0;
      wr_last_r <= '0;
      req_r <= '0;
      pins_r <= '{die_one_select_n: 1'b1, die_two_select_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  identification_high_voltage: 1'b0, addr: '0};
      dq_r <= '0;
      oe_r <= 1'b1;
      rsp_r <= '0;
      rv_r <= 1'b0;
      rdy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_idx_r <= wr_idx_nxt;
      wr_last_r <= wr_last_nxt;
      req_r <= req_nxt;
      pins_r <= pins_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      rsp_r <= rsp_nxt;
      rv_r <= rv_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign pins = pins_r;
  assign dq_out = dq_r;
  assign dq_oe_n = oe_r;
  assign rsp = rsp_r;
  assign rsp_valid = rv_r;
  assign req_ready = rdy_r;

  // ********************************
  // Checks
  // ********************************
  hv_held_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_RD && req_r.op == fai_pkg::FAI_OP_HV) |-> pins_r.identification_high_voltage)
    else $error("high voltage dropped during read");
  group_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_RD) |-> pins_r.addr[fai_pkg::ADDR_W-1:fai_pkg::GROUP_LSB] == req_r.addr[fai_pkg::ADDR_W-1:fai_pkg::GROUP_LSB])
    else $error("group address not on high bits");
  no_bus_fight_a: assert property (@(posedge clk) disable iff (!resetn)
    !pins_r.oe_n |-> dq_oe_n)
    else $error("host drives data during read");
  cmd_byte_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_WR_PULSE && req_r.op == fai_pkg::FAI_OP_ENTER && wr_idx_r == 2'h2)
      |-> dq_r[7:0] == fai_pkg::ID_CMD_DATA && !pins_r.we_n)
    else $error("third write lacks identification command");
  bank_third_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_WR_PULSE && req_r.op == fai_pkg::FAI_OP_ENTER && wr_idx_r == 2'h2)
      |-> pins_r.addr[fai_pkg::BANK_LSB +: 3] == req_r.bank)
    else $error("bank address missing on third write");
  reset_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_WR_PULSE && req_r.op == fai_pkg::FAI_OP_EXIT) |-> dq_r[7:0] == fai_pkg::RESET_DATA)
    else $error("exit does not write reset command");
  write_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_WR_HOLD) |-> pins_r.we_n && !dq_oe_n && $stable(dq_r) && $stable(pins_r.addr))
    else $error("write data moved with rising strobe");
  read_done_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_IDLE && req_valid && rdy_r && req.op == fai_pkg::FAI_OP_READ)
      |-> ##[2:17] rsp_valid)
    else $error("read answer late");
  one_die_a: assert property (@(posedge clk) disable iff (!resetn)
    !(pins_r.die_one_select_n == 1'b0 && pins_r.die_two_select_n == 1'b0))
    else $error("both dies selected");
  enter_cov: cover property (@(posedge clk) st_r == ST_DONE && req_r.op == fai_pkg::FAI_OP_ENTER);
  hv_cov: cover property (@(posedge clk) rsp_valid && req_r.op == fai_pkg::FAI_OP_HV);
  prot_cov: cover property (@(posedge clk) rsp_valid && rsp_r.protected_grp);
  exit_cov: cover property (@(posedge clk) st_r == ST_DONE && req_r.op == fai_pkg::FAI_OP_EXIT);
endmodule
`default_nettype wire

// ---- verification/fai_flash_model.sv ----
// Behavioural dual-die flash answering identification and array reads
`timescale 1ns/100ps
`default_nettype none
module fai_flash_model #(
  parameter logic [15:0] MAKER = 16'h00A5, // Arbitrary code
  parameter logic [15:0] DEV1  = 16'h1234, // Arbitrary code
  parameter logic [15:0] DEV2  = 16'h5678, // Arbitrary code
  parameter logic [15:0] DEV3  = 16'h9ABC, // Arbitrary code
  parameter logic [7:0]  LOCK  = 8'hC0
) (
  input  wire logic               clk,
  input  wire fai_pkg::fai_pins_t pins,
  input  wire logic [15:0]        dq_out,
  output logic [15:0]             dq_in
);
  logic [1:0]  step_r = 2'h0;
  logic        id_r   = 1'b0;
  logic [2:0]  bank_r = 3'h0;
  logic        we_q   = 1'b1;
  logic [15:0] last_r = 16'h0;
  logic        rd;
  logic        idv;
  logic        prot;
  logic [15:0] word;
  assign rd   = ~(pins.die_one_select_n & pins.die_two_select_n) & ~pins.oe_n;
  assign idv  = pins.identification_high_voltage | (id_r & (pins.addr[21:19] == bank_r));
  assign prot = !pins.die_two_select_n ? pins.addr[21:17] == 5'h05 : pins.addr[21:12] == 10'h003;
  always_comb begin
    case (pins.addr[3:0])
      4'h0:    word = MAKER;
      4'h1:    word = DEV1;
      4'hE:    word = DEV2;
      4'hF:    word = DEV3;
      4'h2:    word = {15'h0, prot};
      4'h3:    word = {8'h0, LOCK};
      default: word = 16'hFFFF;
    endcase
    if (!idv) word = pins.addr[15:0] ^ 16'h5A5A;
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign dq_in = rd ? word : ~last_r;
  always @(posedge clk) begin
    we_q <= pins.we_n;
    if (rd) last_r <= dq_in;
    // Command is taken at the rising write strobe
    if (!we_q && pins.we_n) begin
      if (dq_out[7:0] == fai_pkg::RESET_DATA) begin
        id_r <= 1'b0;
        step_r <= 2'h0;
      end else if (step_r == 2'h0 && pins.addr[11:0] == fai_pkg::UNLOCK1_ADDR && dq_out[7:0] == fai_pkg::UNLOCK1_DATA)
        step_r <= 2'h1;
      else if (step_r == 2'h1 && pins.addr[11:0] == fai_pkg::UNLOCK2_ADDR && dq_out[7:0] == fai_pkg::UNLOCK2_DATA)
        step_r <= 2'h2;
      else if (step_r == 2'h2 && pins.addr[11:0] == fai_pkg::UNLOCK1_ADDR && dq_out[7:0] == fai_pkg::ID_CMD_DATA) begin
        id_r <= 1'b1;
        bank_r <= pins.addr[21:19];
        step_r <= 2'h0;
      end else
        step_r <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the identification readout host
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [15:0] CODES [5] = '{16'h00A5, 16'h1234, 16'h5678, 16'h9ABC, 16'h00C0}; // Arbitrary codes
  localparam logic [3:0]  LOCS  [5] = '{4'h0, 4'h1, 4'hE, 4'hF, 4'h3};
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               req_valid = 1'b0;
  fai_pkg::fai_req_t  req = '0;
  logic               req_ready;
  logic               rsp_valid;
  fai_pkg::fai_rsp_t  rsp;
  fai_pkg::fai_pins_t pins;
  logic [15:0]        dq_out;
  logic [15:0]        dq_in;
  logic               dq_oe_n;
  logic               seen_d2 = 1'b0;
  logic [1:0]         seen_a76 = 2'h0;
  logic               wr_oe_n = 1'b1;
  int                 fail_count = 0;
  int                 checked = 0;
  int                 cycles = 0;
  always #50 clk = ~clk;
  fai_host dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  fai_flash_model #(.MAKER(CODES[0]), .DEV1(CODES[1]), .DEV2(CODES[2]), .DEV3(CODES[3]), .LOCK(CODES[4][7:0]))
    flash (.clk(clk), .pins(pins), .dq_out(dq_out), .dq_in(dq_in));
  always @(posedge clk) begin
    if (!pins.oe_n) begin
      seen_d2 <= !pins.die_two_select_n;
      seen_a76 <= pins.addr[7:6];
    end
    if (!pins.we_n) wr_oe_n <= dq_oe_n;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input fai_pkg::fai_op_t op, input logic d2, input logic [2:0] bk, input logic [21:0] a);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    req = '{op: op, die_two: d2, bank: bk, addr: a};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) chk(16'hDEAD, 16'h0000);
  endtask
  // Stray bits in don't-care places must not disturb the decode
  task automatic t_hv;
    for (int i = 0; i < 5; i++) begin
      xfer(fai_pkg::FAI_OP_HV, 1'b0, 3'h0, 22'h2B0D30 | LOCS[i]);
      chk(rsp.word, CODES[i]);
      chk({14'h0, seen_a76}, 16'h0000);
    end
    chk({14'h0, rsp.fact_locked, rsp.cust_locked}, {14'h0, CODES[4][7], CODES[4][6]});
  endtask
  // Neighbouring boot sector and group boundaries on both dies
  task automatic t_prot;
    logic [22:0] q [4] = '{{1'b0, 22'h003002}, {1'b0, 22'h002002}, {1'b1, 22'h0BF002}, {1'b1, 22'h0C0002}};
    for (int i = 0; i < 4; i++) begin
      xfer(fai_pkg::FAI_OP_HV, q[i][22], 3'h0, q[i][21:0]);
      chk(rsp.word, {15'h0, i[0] == 1'b0});
      chk({15'h0, rsp.protected_grp}, {15'h0, i[0] == 1'b0});
      chk({15'h0, seen_d2}, {15'h0, q[i][22]});
    end
  endtask
  task automatic t_cmd(input logic [2:0] bk);
    logic [21:0] base;
    logic [21:0] other;
    base = {bk, 19'h0};
    other = {bk ^ 3'h3, 19'h0};
    xfer(fai_pkg::FAI_OP_ENTER, 1'b0, bk, 22'h0);
    chk({15'h0, wr_oe_n}, 16'h0000);
    xfer(fai_pkg::FAI_OP_READ, 1'b0, 3'h0, base);
    chk(rsp.word, CODES[0]);
    chk({15'h0, dq_oe_n}, 16'h0001);
    xfer(fai_pkg::FAI_OP_READ, 1'b0, 3'h0, other | 22'h1);
    chk(rsp.word, 16'h5A5B);
    xfer(fai_pkg::FAI_OP_READ, 1'b0, 3'h0, base | 22'h1);
    chk(rsp.word, CODES[1]);
    xfer(fai_pkg::FAI_OP_EXIT, 1'b0, 3'h0, 22'h0);
    xfer(fai_pkg::FAI_OP_READ, 1'b0, 3'h0, base);
    chk(rsp.word, 16'h5A5A);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_hv();
    t_prot();
    t_cmd(3'h0);
    t_cmd(3'h5);
    end_sim();
  end
endmodule
`default_nettype wire
